/* include/frs_params.svh */
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH
// Register byte addresses
`define FRS_A_CTRL 8'h00
`define FRS_A_OPT 8'h04
`define FRS_A_FSIM 8'h08
`define FRS_A_TRYA 8'h0C
`define FRS_A_TRYB 8'h10
`define FRS_A_DLYA 8'h14
`define FRS_A_DLYB 8'h18
`define FRS_A_DLYC 8'h1C
`define FRS_A_STAT 8'h20
// Writable bits; reserved bits never stored
`define FRS_OPT_MASK 16'hF00A
`define FRS_FSIM_MASK 10'h019F
// Option bit positions
`define FRS_OPT_EDGE 1
`define FRS_OPT_ONE 3
`define FRS_OPT_NOCUR 12
`define FRS_OPT_NOVOLT 13
`define FRS_OPT_NOFREQ 14
`define FRS_OPT_NOPHC 15
// Control word bit positions
`define FRS_CTRL_CLR 16
// Fault pin positions; positions below 10 shared with the simulation mask
`define FRS_F_OC 0
`define FRS_F_OV 1
`define FRS_F_UV 2
`define FRS_F_PHASE 3
`define FRS_F_EARTH 4
`define FRS_F_OTW 7
`define FRS_F_OTF 8
`define FRS_F_SAT 10
`define FRS_F_IGBT 11
`define FRS_F_REF 12
`define FRS_F_MT 13
`define FRS_F_EXT 14
`define FRS_F_UL 15
// Fastest synchronization speed setting
`define FRS_SPEED_MAX 4'hA
// Time base: delay and window units
`define FRS_CLK_NS 10
`define FRS_TICK_NS 1000000
`define FRS_TICK_CYC (`FRS_TICK_NS / `FRS_CLK_NS)
`endif

/* include/frs_pkg.sv */
`default_nettype none
package frs_pkg;
	typedef enum logic [1:0] {
		FRS_MODE_SINGLE = 2'h0,
		FRS_MODE_MULTI  = 2'h1,
		FRS_MODE_SEQ    = 2'h2
	} frs_mode_t;
	typedef enum logic [2:0] {
		FRS_ST_DRIVE, FRS_ST_TO_GRID, FRS_ST_ON_GRID, FRS_ST_BACK_QUAL, FRS_ST_TO_DRIVE
	} frs_st_t;
	typedef enum logic [2:0] {
		FRS_CLS_OV, FRS_CLS_OC, FRS_CLS_REF, FRS_CLS_MT, FRS_CLS_EXT, FRS_CLS_UL, FRS_CLS_OTHER
	} frs_cls_t;
	typedef struct packed {
		logic [32:0]      s1;
		logic [32:0]      s2;
		logic [31:0]      rdata;
		logic [1:0]       mode;
		logic             bk_sync;
		logic             gen_dis;
		logic [3:0]       speed;
		logic [3:0]       nmot;
		logic [3:0]       ctl_mot;
		logic [15:0]      opt;
		logic [9:0]       fsim;
		logic [5:0][7:0]  tries;
		logic [15:0]      trial;
		logic [15:0]      d_coast;
		logic [15:0]      d_open;
		logic [15:0]      d_close;
		logic [15:0]      d_start;
		logic [15:0]      d_synok;
		logic [15:0]      d_ramp;
		logic [31:0]      div;
		logic             tick;
		logic             faulted;
		logic             perm;
		logic             auto_rst;
		frs_cls_t         fcls;
		logic [5:0][7:0]  cnt;
		logic             win;
		logic [15:0]      w;
		frs_st_t          st;
		logic [15:0]      t;
		logic             modu;
		logic             fc;
		logic             ramp;
		logic             rrun;
		logic [15:0]      rt;
		logic [15:0]      net;
		logic [3:0]       idx;
		logic             armed;
		logic             sync_p;
		logic             rel_p;
	} frs_state_t;
endpackage : frs_pkg
`default_nettype wire

/* verilog/frs_sequencer.sv */
// Summary of operation
// [RULE_01] Overvoltage tries limit resets; zero disables
// [RULE_02] Overcurrent, saturation, switch temperature share tries
// [RULE_03] Reference fault resets after loop recovers
// [RULE_04] Motor temperature resets after model normal
// [RULE_05] External fault tries; zero disables
// [RULE_06] Underload tries; zero disables
// [RULE_07] Simulated fault acts like real one
// [RULE_08] Simulation mask bit to fault mapping
// [RULE_09] Single mode: grid command low opens grid
// [RULE_10] Multi mode: motor select, release input
// [RULE_11] Sequential mode transfers all motors in turn
// [RULE_12] Select inputs override stored controlled motor
// [RULE_13] Three delays after transfer decision
// [RULE_14] Flying start delay, contactor at half
// [RULE_15] Return synchronization enable picks return style
// [RULE_16] Return ready must hold programmed time
// [RULE_17] Voltage ramp delayed after contactor close
// [RULE_18] Speed selector ranges zero to ten
// [RULE_19] Generator side setting gates phase sync
// [RULE_20] Option edge needs sync rising edge
// [RULE_21] Option single release drops one motor
// [RULE_22] Option bits drop interlock checks
// [RULE_23] Window from first reset; excess faults permanent
// [RULE_24] Reserved mask and option bits ignored
`include "frs_params.svh"
`default_nettype none
module frs_sequencer
	import frs_pkg::*;
#(
	parameter int TICK_CYC = `FRS_TICK_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_fault_pins,
	input  wire logic        i_loop_ok,
	input  wire logic        i_mtemp_ok,
	input  wire logic        i_sync_cmd,
	input  wire logic        i_grid_cmd,
	input  wire logic        i_grid_release,
	input  wire logic        i_motor_sel_valid,
	input  wire logic [3:0]  i_motor_sel,
	input  wire logic        i_phase_ok,
	input  wire logic        i_freq_rise,
	input  wire logic        i_back_ok,
	input  wire logic        i_cur_ok,
	input  wire logic        i_volt_ok,
	input  wire logic        i_freq_ok,
	input  wire logic        i_phcur_ok,
	output logic      [31:0] o_rdata,
	output logic             o_fault,
	output logic             o_permanent_fault,
	output logic      [2:0]  o_fault_class,
	output logic             o_warning,
	output logic             o_auto_reset,
	output logic             o_modulation_on,
	output logic             o_drive_contactor,
	output logic      [15:0] o_grid_contactor,
	output logic      [3:0]  o_motor_index,
	output logic             o_volt_ramp,
	output logic             o_phase_sync_en,
	output logic      [3:0]  o_sync_speed
);
	function automatic logic [15:0] inc16(input logic [15:0] v);
		inc16 = (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
	endfunction : inc16

	frs_state_t q;
	frs_state_t d;
	logic [32:0] pins_in;
	logic [15:0] eff;
	logic [6:0]  cls;
	logic        flt_any;
	frs_cls_t    k;
	logic        loop_ok, mt_ok, sync_c, grid_c, rel_c, selv, phase_ok;
	logic        frise, back_ok, ilk, phase_en, go, rel_ev, cause_gone;
	logic [3:0]  sel, nxt_idx;
	logic        clr_wr;

	assign pins_in = {i_phcur_ok, i_freq_ok, i_volt_ok, i_cur_ok, i_back_ok, i_freq_rise,
		i_phase_ok, i_motor_sel, i_motor_sel_valid, i_grid_release, i_grid_cmd,
		i_sync_cmd, i_mtemp_ok, i_loop_ok, i_fault_pins};
	assign loop_ok  = q.s2[16];
	assign mt_ok    = q.s2[17];
	assign sync_c   = q.s2[18];
	assign grid_c   = q.s2[19];
	assign rel_c    = q.s2[20];
	assign selv     = q.s2[21];
	assign sel      = q.s2[25:22];
	assign phase_ok = q.s2[26];
	assign frise    = q.s2[27];
	assign back_ok  = q.s2[28];
	// Simulated faults join the pins after the synchronizer, so every later path treats them alike
	assign eff = q.s2[15:0] | {6'h00, q.fsim}; // RULE_07 RULE_08
	assign cls = {eff[`FRS_F_UV] | eff[`FRS_F_PHASE] | eff[`FRS_F_EARTH] | eff[`FRS_F_OTF],
		eff[`FRS_F_UL], eff[`FRS_F_EXT], eff[`FRS_F_MT], eff[`FRS_F_REF],
		eff[`FRS_F_OC] | eff[`FRS_F_SAT] | eff[`FRS_F_IGBT], // RULE_02
		eff[`FRS_F_OV]};
	assign flt_any = |cls;
	assign ilk = (q.s2[29] | q.opt[`FRS_OPT_NOCUR]) & (q.s2[30] | q.opt[`FRS_OPT_NOVOLT])
		& (q.s2[31] | q.opt[`FRS_OPT_NOFREQ]) & (q.s2[32] | q.opt[`FRS_OPT_NOPHC]); // RULE_22
	assign phase_en = !q.gen_dis | frise; // RULE_19
	assign go = sync_c & grid_c & phase_ok & phase_en & ilk & !q.faulted
		& (!q.opt[`FRS_OPT_EDGE] | q.armed); // RULE_20
	assign rel_ev = (q.mode == FRS_MODE_SINGLE) ? !grid_c : (rel_c & !q.rel_p); // RULE_09 RULE_10
	assign nxt_idx = 4'(q.idx + 4'h1);
	assign cause_gone = !cls[q.fcls] && ((q.fcls == FRS_CLS_REF) ? loop_ok : // RULE_03
		(q.fcls == FRS_CLS_MT) ? mt_ok : 1'b1); // RULE_04
	assign clr_wr = i_wr && i_addr == `FRS_A_CTRL && i_wdata[`FRS_CTRL_CLR];

	always_comb begin
		d = q;
		k = FRS_CLS_OTHER;
		d.s1 = pins_in;
		d.s2 = q.s1;
		d.auto_rst = 1'b0;
		d.tick = 1'b0;
		d.sync_p = sync_c;
		d.rel_p = rel_c;
		if (q.div >= 32'(TICK_CYC - 1)) begin
			d.div = 32'h0000_0000;
			d.tick = 1'b1;
		end else begin
			d.div = 32'(q.div + 32'h0000_0001);
		end
		d.rdata = 32'h0000_0000;
		if (i_rd) begin
			unique case (i_addr)
				`FRS_A_CTRL: d.rdata = {16'h0000, q.ctl_mot, q.nmot, q.speed, q.gen_dis,
					q.bk_sync, q.mode};
				`FRS_A_OPT:  d.rdata = {16'h0000, q.opt};
				`FRS_A_FSIM: d.rdata = {22'h00_0000, q.fsim};
				`FRS_A_TRYA: d.rdata = q.tries[3:0];
				`FRS_A_TRYB: d.rdata = {q.trial, q.tries[5:4]};
				`FRS_A_DLYA: d.rdata = {q.d_open, q.d_coast};
				`FRS_A_DLYB: d.rdata = {q.d_start, q.d_close};
				`FRS_A_DLYC: d.rdata = {q.d_ramp, q.d_synok};
				`FRS_A_STAT: d.rdata = {q.net, 3'h0, q.idx, q.fc, q.fcls, q.perm, q.faulted,
					q.st};
				default:     d.rdata = 32'h0000_0000;
			endcase
		end
		if (i_wr) begin
			unique case (i_addr)
				`FRS_A_CTRL: begin
					d.mode = (i_wdata[1:0] == 2'h3) ? q.mode : i_wdata[1:0];
					d.bk_sync = i_wdata[2]; // RULE_15
					d.gen_dis = i_wdata[3];
					// Above ten saturates so the speed scale stays monotonic
					d.speed = (i_wdata[7:4] > `FRS_SPEED_MAX) ? `FRS_SPEED_MAX : i_wdata[7:4]; // RULE_18
					d.nmot = i_wdata[11:8];
					d.ctl_mot = i_wdata[15:12];
				end
				`FRS_A_OPT:  d.opt = i_wdata[15:0] & `FRS_OPT_MASK; // RULE_24
				`FRS_A_FSIM: d.fsim = i_wdata[9:0] & `FRS_FSIM_MASK; // RULE_24
				`FRS_A_TRYA: d.tries[3:0] = i_wdata;
				`FRS_A_TRYB: begin
					d.tries[5:4] = i_wdata[15:0];
					d.trial = i_wdata[31:16];
				end
				`FRS_A_DLYA: begin
					d.d_coast = i_wdata[15:0];
					d.d_open = i_wdata[31:16];
				end
				`FRS_A_DLYB: begin
					d.d_close = i_wdata[15:0];
					d.d_start = i_wdata[31:16];
				end
				`FRS_A_DLYC: begin
					d.d_synok = i_wdata[15:0];
					d.d_ramp = i_wdata[31:16];
				end
				default: ;
			endcase
		end
		// Trial window; expiry forgets the fault history
		if (q.win) begin
			if (q.w >= q.trial) begin
				d.win = 1'b0;
				d.cnt = '0;
			end else if (q.tick) begin
				d.w = inc16(q.w);
			end
		end
		for (int i = 6; i >= 0; i--) begin
			if (cls[i]) begin
				k = frs_cls_t'(i[2:0]);
			end
		end
		if (!q.faulted && flt_any) begin
			d.faulted = 1'b1;
			d.fcls = k;
			if (k == FRS_CLS_OTHER) begin
				d.perm = 1'b1;
			end else begin
				d.cnt[k] = (q.cnt[k] == 8'hFF) ? q.cnt[k] : 8'(q.cnt[k] + 8'h01);
				if (q.cnt[k] >= q.tries[k]) begin
					d.perm = 1'b1; // RULE_01 RULE_05 RULE_06 RULE_23
				end
			end
		end else if (q.faulted && !q.perm && cause_gone) begin
			d.faulted = 1'b0;
			d.auto_rst = 1'b1;
			if (!q.win) begin
				d.win = 1'b1; // RULE_23
				d.w = 16'h0000;
			end
		end
		// A pending fault level re-latches on the next cycle, so no event is lost
		if (clr_wr) begin
			d.faulted = 1'b0;
			d.perm = 1'b0;
			d.cnt = '0;
			d.win = 1'b0;
		end
		if (sync_c && !q.sync_p) begin
			d.armed = 1'b1;
		end
		unique case (q.st)
			FRS_ST_DRIVE: begin
				d.fc = 1'b1;
				d.modu = !q.faulted;
				if (q.mode == FRS_MODE_MULTI) begin
					d.idx = selv ? sel : q.ctl_mot; // RULE_12
				end else if (q.mode == FRS_MODE_SINGLE) begin
					d.idx = 4'h0;
				end
				if (go) begin
					d.st = FRS_ST_TO_GRID;
					d.t = 16'h0000;
				end
			end
			FRS_ST_TO_GRID: begin
				if (q.tick) begin
					d.t = inc16(q.t);
				end
				if (q.t >= q.d_coast) begin
					d.modu = 1'b0; // RULE_13
				end
				if (q.t >= q.d_open) begin
					d.fc = 1'b0; // RULE_13
				end
				if (q.t >= q.d_close) begin
					d.net[q.idx] = 1'b1; // RULE_13
				end
				if (q.t >= q.d_coast && q.t >= q.d_open && q.t >= q.d_close) begin
					d.st = FRS_ST_ON_GRID;
					d.armed = 1'b0;
				end
			end
			FRS_ST_ON_GRID: begin
				if (q.mode == FRS_MODE_SEQ && sync_c && grid_c && {1'b0, q.idx} + 5'h01
						< {1'b0, q.nmot}) begin
					d.idx = nxt_idx; // RULE_11
					d.st = FRS_ST_TO_DRIVE;
					d.t = 16'h0000;
				end else if (rel_ev) begin
					if (q.opt[`FRS_OPT_ONE]) begin
						d.net[q.idx] = 1'b0; // RULE_21
					end else begin
						d.net = 16'h0000;
						d.idx = (q.mode == FRS_MODE_SEQ) ? 4'h0 : q.idx;
					end
					d.st = q.bk_sync ? FRS_ST_BACK_QUAL : FRS_ST_TO_DRIVE; // RULE_15
					d.t = 16'h0000;
				end
			end
			FRS_ST_BACK_QUAL: begin
				if (!back_ok) begin
					d.t = 16'h0000; // RULE_16
				end else if (q.t >= q.d_synok) begin
					d.fc = 1'b1; // RULE_16
					d.modu = 1'b1;
					d.st = FRS_ST_DRIVE;
				end else if (q.tick) begin
					d.t = inc16(q.t);
				end
			end
			FRS_ST_TO_DRIVE: begin
				if (q.tick) begin
					d.t = inc16(q.t);
				end
				if (q.t >= {1'b0, q.d_start[15:1]}) begin
					d.fc = 1'b1; // RULE_14
				end
				if (q.t >= q.d_start) begin
					d.modu = 1'b1; // RULE_14
					d.st = FRS_ST_DRIVE;
				end
			end
		endcase
		// Ramp timer restarts on each close command
		if (d.fc && !q.fc) begin
			d.rrun = 1'b1;
			d.rt = 16'h0000;
			d.ramp = 1'b0;
		end else if (!q.fc) begin
			d.rrun = 1'b0;
			d.ramp = 1'b0;
		end else if (q.rrun) begin
			if (q.rt >= q.d_ramp) begin
				d.ramp = 1'b1; // RULE_17
				d.rrun = 1'b0;
			end else if (q.tick) begin
				d.rt = inc16(q.rt);
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_rdata = q.rdata;
	assign o_fault = q.faulted;
	assign o_permanent_fault = q.perm;
	assign o_fault_class = q.fcls;
	assign o_warning = eff[`FRS_F_OTW];
	assign o_auto_reset = q.auto_rst;
	assign o_modulation_on = q.modu;
	assign o_drive_contactor = q.fc;
	assign o_grid_contactor = q.net;
	assign o_motor_index = q.idx;
	assign o_volt_ramp = q.ramp;
	assign o_phase_sync_en = phase_en;
	assign o_sync_speed = q.speed;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	chk_ov_zero_tries: assert property ($rose(q.faulted) && q.fcls == FRS_CLS_OV // RULE_01
		&& $past(q.tries[0]) == 8'h00 |-> q.perm) else $error("ov zero tries not permanent");
	chk_oc_shared_class: assert property (!q.faulted && eff[`FRS_F_SAT] && !cls[0] // RULE_02
		&& !clr_wr |=> q.faulted && q.fcls == FRS_CLS_OC)
		else $error("saturation not in oc class");
	chk_ref_loop_ok: assert property (q.auto_rst && $past(q.fcls) == FRS_CLS_REF // RULE_03
		|-> $past(loop_ok)) else $error("ref reset before loop recovered");
	chk_mt_model_ok: assert property (q.auto_rst && $past(q.fcls) == FRS_CLS_MT // RULE_04
		|-> $past(mt_ok)) else $error("motor temp reset before normal");
	chk_sim_fault_raise: assert property (q.fsim[1] && !q.faulted && !clr_wr // RULE_07
		|=> q.faulted) else $error("simulated fault not raised");
	chk_single_grid_open: assert property (q.st == FRS_ST_ON_GRID // RULE_09
		&& q.mode == FRS_MODE_SINGLE && !grid_c && !q.opt[`FRS_OPT_ONE] |=> q.net == 16'h0000)
		else $error("grid contactor kept closed");
	chk_flying_half: assert property ($rose(q.fc) && $past(q.st) == FRS_ST_TO_DRIVE // RULE_14
		|-> $past(q.t) >= {1'b0, $past(q.d_start[15:1])}) else $error("contactor closed early");
	chk_return_qual: assert property ($rose(q.fc) && $past(q.st) == FRS_ST_BACK_QUAL // RULE_16
		|-> $past(back_ok) && $past(q.t) >= $past(q.d_synok)) else $error("return not held");
	chk_reserved_ignored: assert property ((q.opt & ~`FRS_OPT_MASK) == 16'h0000 // RULE_24
		&& (q.fsim & ~`FRS_FSIM_MASK) == 10'h000) else $error("reserved bit stored");
	chk_edge_needs_arm: assert property (q.st == FRS_ST_DRIVE && q.opt[`FRS_OPT_EDGE] // RULE_20
		&& !q.armed |=> q.st != FRS_ST_TO_GRID) else $error("transfer without sync edge");
	chk_ramp_after_delay: assert property ($rose(q.ramp) |-> $past(q.rrun) // RULE_17
		&& $past(q.rt) >= $past(q.d_ramp)) else $error("voltage ramp early");
endmodule : frs_sequencer
`default_nettype wire

/* dv/frs_plant.sv */
`default_nettype none
module frs_plant #(
	parameter int LAG = 3
) (
	input  wire logic        i_clk,
	input  wire logic        i_sync_en,
	input  wire logic        i_drive_on,
	input  wire logic [15:0] i_grid_on,
	output logic             o_phase_ok,
	output logic             o_back_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	int ph_q = 0;
	int bk_q = 0;
	// Phase lock builds while sync is enabled and the drive feeds a motor; earlier motors may sit on the grid
	always @(posedge i_clk) begin
		if (i_sync_en && i_drive_on) begin
			ph_q <= (ph_q < LAG) ? ph_q + 1 : ph_q;
		end else begin
			ph_q <= 0;
		end
		// Coasting motor matches the drive only after both contactors are open
		if (!i_drive_on && !(|i_grid_on)) begin
			bk_q <= (bk_q < LAG) ? bk_q + 1 : bk_q;
		end else begin
			bk_q <= 0;
		end
	end
	assign o_phase_ok = (ph_q >= LAG);
	assign o_back_ok  = (bk_q >= LAG);
endmodule : frs_plant
`default_nettype wire

/* dv/frs_sequencer_tb.sv */
`include "frs_params.svh"
`default_nettype none
module frs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk   = 1'b0;
	logic        reset_n   = 1'b0;
	logic [7:0]  addr      = 8'h00;
	logic [31:0] wdata     = 32'h0000_0000;
	logic        wr_s      = 1'b0;
	logic        rd_s      = 1'b0;
	logic [15:0] pins      = 16'h0000;
	logic        loop_ok   = 1'b1;
	logic        mtemp_ok  = 1'b1;
	logic        sync_cmd  = 1'b0;
	logic        grid_cmd  = 1'b0;
	logic        grid_rel  = 1'b0;
	logic        sel_v     = 1'b0;
	logic [3:0]  sel       = 4'h0;
	logic        freq_rise = 1'b0;
	logic        cur_ok    = 1'b1;
	logic        phase_ok;
	logic        back_ok;
	logic [31:0] rdata;
	logic [31:0] rd_d;
	logic        fault;
	logic        perm;
	logic [2:0]  fcls;
	logic        warn;
	logic        arst;
	logic        modu;
	logic        dcon;
	logic [15:0] gcon;
	logic [3:0]  midx;
	logic        ramp;
	logic        psen;
	logic [3:0]  speed;
	int          bad_count   = 0;
	int          checks_done = 0;
	always #5 ref_clk = ~ref_clk;
	frs_sequencer #(.TICK_CYC(4)) i_frs_sequencer (
		.i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .i_fault_pins(pins), .i_loop_ok(loop_ok),
		.i_mtemp_ok(mtemp_ok), .i_sync_cmd(sync_cmd), .i_grid_cmd(grid_cmd),
		.i_grid_release(grid_rel), .i_motor_sel_valid(sel_v), .i_motor_sel(sel),
		.i_phase_ok(phase_ok), .i_freq_rise(freq_rise), .i_back_ok(back_ok),
		.i_cur_ok(cur_ok), .i_volt_ok(1'b1), .i_freq_ok(1'b1), .i_phcur_ok(1'b1),
		.o_rdata(rdata), .o_fault(fault), .o_permanent_fault(perm), .o_fault_class(fcls),
		.o_warning(warn), .o_auto_reset(arst), .o_modulation_on(modu),
		.o_drive_contactor(dcon), .o_grid_contactor(gcon), .o_motor_index(midx),
		.o_volt_ramp(ramp), .o_phase_sync_en(psen), .o_sync_speed(speed));
	frs_plant i_frs_plant (.i_clk(ref_clk), .i_sync_en(psen), .i_drive_on(dcon),
		.i_grid_on(gcon), .o_phase_ok(phase_ok), .o_back_ok(back_ok));
	task automatic chk(input bit ok, input string msg);
		checks_done++;
		if (!ok) begin
			bad_count++;
			$display("ERROR t=%0t %s", $time, msg);
		end
	endtask : chk
	// Reads see values settled in the previous cycle, drives land by NBA at the edge
	task automatic step;
		@(posedge ref_clk);
	endtask : step
	task automatic cyc(input int n);
		repeat (n) step();
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		step();
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		step();
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		step();
		addr <= a;
		rd_s <= 1'b1;
		step();
		rd_s <= 1'b0;
		step();
		rd_d = rdata;
	endtask : rd
	task automatic calm;
		pins <= 16'h0000;
		cyc(3);
		wr(`FRS_A_CTRL, 32'h0001_0000);
		cyc(3);
		chk(fault === 1'b0 && perm === 1'b0, "clear failed");
	endtask : calm
	task automatic rise(input int b, input logic [2:0] c, input logic p);
		pins <= 16'h0001 << b;
		cyc(6);
		chk(fault === 1'b1 && fcls === c && perm === p, "trip wrong");
	endtask : rise
	task automatic await(output bit got);
		got = 1'b0;
		repeat (8) begin
			step();
			if (arst === 1'b1 && fault === 1'b0) got = 1'b1;
		end
	endtask : await
	task automatic t_regs;
		rd(`FRS_A_STAT);
		chk(rd_d[2:0] === 3'h0 && rd_d[8] === 1'b1, "reset status");
		rd(8'h24);
		chk(rd_d === 32'h0000_0000, "unmapped read");
		wr(`FRS_A_OPT, 32'hFFFF_FFFF);
		rd(`FRS_A_OPT);
		chk(rd_d === 32'h0000_F00A, "option mask");
		wr(`FRS_A_OPT, 32'h0000_0000);
		wr(`FRS_A_FSIM, 32'h0000_0260);
		cyc(6);
		chk(fault === 1'b0 && warn === 1'b0, "reserved sim bits");
		wr(`FRS_A_FSIM, 32'h0000_0000);
		wr(`FRS_A_CTRL, 32'h0000_00FB);
		cyc(4);
		rd(`FRS_A_CTRL);
		chk(rd_d === 32'h0000_00A8, "mode three kept out");
		chk(speed === 4'hA, "speed clamp");
		chk(psen === 1'b0, "generator side off");
		freq_rise <= 1'b1;
		cyc(5);
		chk(psen === 1'b1, "motoring side on");
		freq_rise <= 1'b0;
		$display("test regs done");
	endtask : t_regs
	task automatic t_sim;
		int         bits[6] = '{0, 1, 2, 3, 4, 8};
		logic [2:0] cls[6]  = '{3'h1, 3'h0, 3'h6, 3'h6, 3'h6, 3'h6};
		wr(`FRS_A_TRYA, 32'h0000_0000);
		wr(`FRS_A_TRYB, 32'h0100_0000);
		wr(`FRS_A_CTRL, 32'h0000_0000);
		foreach (bits[i]) begin
			wr(`FRS_A_FSIM, 32'h0000_0001 << bits[i]);
			cyc(4);
			chk(fault === 1'b1 && perm === 1'b1 && fcls === cls[i], "sim fault");
			wr(`FRS_A_FSIM, 32'h0000_0000);
			calm();
		end
		wr(`FRS_A_FSIM, 32'h0000_0080);
		cyc(4);
		chk(warn === 1'b1 && fault === 1'b0, "sim warning");
		wr(`FRS_A_FSIM, 32'h0000_0000);
		$display("test sim done");
	endtask : t_sim
	task automatic t_auto;
		bit got;
		wr(`FRS_A_TRYA, 32'h0101_0001);
		rise(`FRS_F_OV, 3'h0, 1'b0);
		pins <= 16'h0000;
		await(got);
		chk(got === 1'b1, "no auto reset");
		rise(`FRS_F_OV, 3'h0, 1'b1);
		calm();
		loop_ok <= 1'b0;
		rise(`FRS_F_REF, 3'h2, 1'b0);
		pins <= 16'h0000;
		await(got);
		chk(got === 1'b0, "reset before loop ok");
		loop_ok <= 1'b1;
		await(got);
		chk(got === 1'b1, "loop reset missing");
		mtemp_ok <= 1'b0;
		rise(`FRS_F_MT, 3'h3, 1'b0);
		pins <= 16'h0000;
		await(got);
		chk(got === 1'b0, "reset before model ok");
		mtemp_ok <= 1'b1;
		await(got);
		chk(got === 1'b1, "model reset missing");
		rise(`FRS_F_SAT, 3'h1, 1'b1);
		calm();
		rise(`FRS_F_IGBT, 3'h1, 1'b1);
		calm();
		rise(`FRS_F_EXT, 3'h4, 1'b1);
		calm();
		rise(`FRS_F_UL, 3'h5, 1'b1);
		calm();
		wr(`FRS_A_TRYB, 32'h0004_0000);
		rise(`FRS_F_OV, 3'h0, 1'b0);
		pins <= 16'h0000;
		await(got);
		chk(got === 1'b1, "window reset missing");
		cyc(30);
		rise(`FRS_F_OV, 3'h0, 1'b0);
		calm();
		$display("test auto done");
	endtask : t_auto
	task automatic t_xfer;
		int n;
		int m;
		wr(`FRS_A_DLYA, 32'h0000_0000);
		wr(`FRS_A_DLYB, 32'h0002_0000);
		wr(`FRS_A_DLYC, 32'h0003_0002);
		wr(`FRS_A_CTRL, 32'h0000_0100);
		cur_ok   <= 1'b0;
		sync_cmd <= 1'b1;
		grid_cmd <= 1'b1;
		cyc(40);
		chk(gcon === 16'h0000, "interlock ignored");
		wr(`FRS_A_OPT, 32'h0000_1000);
		for (n = 0; n < 60 && gcon !== 16'h0001; n++) step();
		chk(gcon === 16'h0001 && dcon === 1'b0 && modu === 1'b0, "on grid");
		grid_cmd <= 1'b0;
		sync_cmd <= 1'b0;
		for (n = 0; n < 60 && dcon !== 1'b1; n++) step();
		chk(gcon === 16'h0000 && dcon === 1'b1 && modu === 1'b0, "half delay");
		for (m = 0; m < 60 && modu !== 1'b1; m++) step();
		chk(m > 0 && m < 12, "flying start");
		for (n = m; n < 60 && ramp !== 1'b1; n++) step();
		chk(n >= 11 && n <= 18, "ramp delay");
		wr(`FRS_A_OPT, 32'h0000_0000);
		cur_ok <= 1'b1;
		$display("test transfer done");
	endtask : t_xfer
	task automatic t_seq;
		int n;
		wr(`FRS_A_OPT, 32'h0000_000A);
		wr(`FRS_A_CTRL, 32'h0000_0202);
		sync_cmd <= 1'b1;
		grid_cmd <= 1'b1;
		for (n = 0; n < 60 && gcon !== 16'h0001; n++) step();
		cyc(30);
		chk(gcon === 16'h0001 && midx === 4'h1 && modu === 1'b1, "next waits edge");
		sync_cmd <= 1'b0;
		cyc(4);
		sync_cmd <= 1'b1;
		for (n = 0; n < 60 && gcon !== 16'h0003; n++) step();
		chk(gcon === 16'h0003 && midx === 4'h1 && dcon === 1'b0, "sequence done");
		sync_cmd <= 1'b0;
		grid_cmd <= 1'b0;
		grid_rel <= 1'b1;
		cyc(8);
		chk(gcon === 16'h0001, "one motor released");
		grid_rel <= 1'b0;
		reset_n  <= 1'b0;
		cyc(2);
		reset_n <= 1'b1;
		cyc(2);
		chk(gcon === 16'h0000 && dcon === 1'b1 && midx === 4'h0, "mid-run reset");
		$display("test sequence done");
	endtask : t_seq
	task automatic t_multi;
		int n;
		wr(`FRS_A_DLYC, 32'h0003_0002);
		wr(`FRS_A_CTRL, 32'h0000_2405);
		sel_v    <= 1'b1;
		sel      <= 4'h3;
		sync_cmd <= 1'b1;
		grid_cmd <= 1'b1;
		for (n = 0; n < 60 && gcon === 16'h0000; n++) step();
		chk(gcon === 16'h0008 && midx === 4'h3, "selected motor");
		sync_cmd <= 1'b0;
		cyc(10);
		chk(gcon === 16'h0008, "left grid unasked");
		grid_rel <= 1'b1;
		for (n = 0; n < 80 && dcon !== 1'b1; n++) step();
		chk(gcon === 16'h0000 && dcon === 1'b1 && modu === 1'b1, "sync return");
		grid_rel <= 1'b0;
		grid_cmd <= 1'b0;
		sel_v    <= 1'b0;
		$display("test multi done");
	endtask : t_multi
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	initial begin
		cyc(3);
		reset_n <= 1'b1;
		cyc(2);
		t_regs();
		t_sim();
		t_auto();
		t_xfer();
		t_seq();
		t_multi();
		final_report();
	end
	// All scenarios fit in a few thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end
endmodule : frs_sequencer_tb
`default_nettype wire
